// ---- hw/sdlsr_pkg.sv ----
// Package: offsets, field positions and reset values of the SerDes lane register bank
package sdlsr_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] SERDES_BASE = 12'h800;
  localparam logic [ADDR_W-1:0] OFS_TXRX_STAT = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_OUT_STAT = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_RX_OVRD = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_DBG_CTL = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_PM_CTL = 12'h02c;
  localparam logic [ADDR_W-1:0] OFS_EC_CTL = 12'h030;
  localparam logic [ADDR_W-1:0] OFS_SCOPE_FI = 12'h034;
  localparam logic [ADDR_W-1:0] OFS_CLK_STAT = 12'h420;
  localparam logic [ADDR_W-1:0] OFS_CLK_OVRD = 12'h428;
  // Lane status field positions
  localparam int unsigned LOS_LSB = 28;
  localparam int unsigned EQ_LSB = 21;
  localparam int unsigned ALIGN_BIT = 19;
  localparam int unsigned HALF_BIT = 16;
  localparam int unsigned BOOST_LSB = 6;
  // Fixed reserved levels of the lane status register
  localparam logic [1:0] STAT_TOP_RSV = 2'h1;
  localparam logic [5:0] STAT_MID_RSV = 6'h20;
  // Defaults of the power-up control inputs
  localparam logic [3:0] BOOST_RST = 4'hb;
  localparam logic [2:0] EQ_RST = 3'h2;
  // Output status / tx override fields
  localparam int unsigned OVRD_BIT = 31;
  localparam int unsigned OUT_BOOST_LSB = 22;
  localparam int unsigned OUT_LOS_BIT = 2;
  // Rx override fields
  localparam int unsigned OVRD2_BIT = 14;
  localparam int unsigned RXO_LOS_LSB = 12;
  localparam int unsigned RXO_EQ_LSB = 5;
  localparam int unsigned RXO_ALIGN_BIT = 3;
  localparam int unsigned RXO_HALF_BIT = 0;
  localparam logic [31:0] OUT_STAT_RST = 32'h0000_0000;
  localparam logic [31:0] RX_OVRD_RST = 32'h0000_101e;
  localparam logic [31:0] PLAIN_RST = 32'h0000_0000;
endpackage

// ---- hw/sdlsr_sync.sv ----
// Two-flop synchroniser for a bus of levels
`timescale 1ns/1ps
module sdlsr_sync #(
  parameter int unsigned W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ---- hw/sdlsr_reg.sv ----
// Software-writable 32-bit register with a per-bit write mask
`timescale 1ns/1ps
module sdlsr_reg #(
  parameter logic [31:0] RST = 32'h0000_0000,
  parameter logic [31:0] WMASK = 32'hffff_ffff
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [31:0] wdata,
  output logic [31:0] q
);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST;
    end else if (we) begin
      q <= (wdata & WMASK) | (q & ~WMASK);
    end
  end
endmodule

// ---- hw/sdlsr_top.sv ----
// SerDes lane control and status register bank
// Behaviour
// - Registers decode at base 0x800 plus their offset.
// - Lane registers at 0x000-0x00c,0x02c-0x034; clock-module at 0x420, 0x428.
// - Lane status shows power-up levels of the SerDes control inputs.
// - With overrides in use, affected lane status fields are not valid.
// - Loss-of-signal filter mode read-only in bits 29:28.
// - Half-rate setting read-only in bit 16.
// - Transmit boost read-only in bits 9:6, reset 0b1011.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module sdlsr_top (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [1:0] signal_loss_filter_mode,
  input wire logic [2:0] receive_equaliser_setting,
  input wire logic align_enable,
  input wire logic half_rate,
  input wire logic [3:0] tx_boost,
  input wire logic serdes_los,
  input wire logic [31:0] clk_level_status,
  output logic [1:0] filter_mode_out,
  output logic [2:0] rx_eq_out,
  output logic align_en_out,
  output logic half_rate_out,
  output logic [3:0] tx_boost_out,
  output logic status_valid,
  output logic access_error
);
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // SerDes control inputs and status pins come from outside mclk
  logic [10:0] pin_sync;
  logic [31:0] clk_lvl_sync;
  logic los_sync;
  sdlsr_sync #(.W(11)) u_sync_ctl (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({signal_loss_filter_mode, receive_equaliser_setting, align_enable, half_rate, tx_boost}),
    .q(pin_sync)
  );
  sdlsr_sync #(.W(33)) u_sync_stat (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({serdes_los, clk_level_status}),
    .q({los_sync, clk_lvl_sync})
  );

  // Power-up levels caught once, after reset release
  logic [1:0] cap_los;
  logic [2:0] cap_eq;
  logic cap_align;
  logic cap_half;
  logic [3:0] cap_boost;
  logic [1:0] cap_cnt;
  logic cap_done;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cap_cnt <= 2'h0;
      cap_done <= 1'b0;
      cap_los <= 2'h0;
      cap_eq <= sdlsr_pkg::EQ_RST;
      cap_align <= 1'b0;
      cap_half <= 1'b0;
      cap_boost <= sdlsr_pkg::BOOST_RST;
    end else if (!cap_done) begin
      cap_cnt <= cap_cnt + 2'h1;
      if (cap_cnt == 2'h3) begin
        cap_done <= 1'b1;
        {cap_los, cap_eq, cap_align, cap_half, cap_boost} <= pin_sync;
      end
    end
  end

  // absolute decode at base plus offset
  wire in_space = addr[11] == 1'b1;
  wire [11:0] ofs = addr - sdlsr_pkg::SERDES_BASE;
  wire hit_stat = in_space && ofs == sdlsr_pkg::OFS_TXRX_STAT;
  wire hit_out = in_space && ofs == sdlsr_pkg::OFS_OUT_STAT;
  wire hit_rxo = in_space && ofs == sdlsr_pkg::OFS_RX_OVRD;
  wire hit_dbg = in_space && ofs == sdlsr_pkg::OFS_DBG_CTL;
  wire hit_pm = in_space && ofs == sdlsr_pkg::OFS_PM_CTL;
  wire hit_ec = in_space && ofs == sdlsr_pkg::OFS_EC_CTL;
  wire hit_fi = in_space && ofs == sdlsr_pkg::OFS_SCOPE_FI;
  wire hit_cks = in_space && ofs == sdlsr_pkg::OFS_CLK_STAT;
  wire hit_cko = in_space && ofs == sdlsr_pkg::OFS_CLK_OVRD;
  wire hit_any = hit_stat | hit_out | hit_rxo | hit_dbg | hit_pm | hit_ec | hit_fi | hit_cks | hit_cko;

  logic [31:0] out_reg;
  logic [31:0] rxo_reg;
  logic [31:0] dbg_reg;
  logic [31:0] pm_reg;
  logic [31:0] ec_reg;
  logic [31:0] fi_reg;
  logic [31:0] cko_reg;
  // Bit 2 and 1:0 of output status are hardware-owned
  sdlsr_reg #(.RST(sdlsr_pkg::OUT_STAT_RST), .WMASK(32'hffff_fff8)) u_out (
    .mclk(mclk),
    .rst_n(rst_n),
    .we(wr && hit_out),
    .wdata(wdata),
    .q(out_reg)
  );
  // Bits 31:15 of rx override are read-only
  sdlsr_reg #(.RST(sdlsr_pkg::RX_OVRD_RST), .WMASK(32'h0000_7fff)) u_rxo (
    .mclk(mclk),
    .rst_n(rst_n),
    .we(wr && hit_rxo),
    .wdata(wdata),
    .q(rxo_reg)
  );
  // Plain registers: no hardware-owned bits
  sdlsr_reg #(.RST(sdlsr_pkg::PLAIN_RST)) u_dbg (
    .mclk(mclk),
    .rst_n(rst_n),
    .we(wr && hit_dbg),
    .wdata(wdata),
    .q(dbg_reg)
  );
  sdlsr_reg #(.RST(sdlsr_pkg::PLAIN_RST)) u_pm (
    .mclk(mclk),
    .rst_n(rst_n),
    .we(wr && hit_pm),
    .wdata(wdata),
    .q(pm_reg)
  );
  sdlsr_reg #(.RST(sdlsr_pkg::PLAIN_RST)) u_ec (
    .mclk(mclk),
    .rst_n(rst_n),
    .we(wr && hit_ec),
    .wdata(wdata),
    .q(ec_reg)
  );
  sdlsr_reg #(.RST(sdlsr_pkg::PLAIN_RST)) u_fi (
    .mclk(mclk),
    .rst_n(rst_n),
    .we(wr && hit_fi),
    .wdata(wdata),
    .q(fi_reg)
  );
  sdlsr_reg #(.RST(sdlsr_pkg::PLAIN_RST)) u_cko (
    .mclk(mclk),
    .rst_n(rst_n),
    .we(wr && hit_cko),
    .wdata(wdata),
    .q(cko_reg)
  );

  wire tx_ovrd = out_reg[sdlsr_pkg::OVRD_BIT];
  wire rx_ovrd = rxo_reg[sdlsr_pkg::OVRD2_BIT];

  wire [1:0] f_los = cap_los;
  wire [2:0] f_eq = cap_eq;
  wire f_align = cap_align;
  wire f_half = cap_half;
  wire [3:0] f_boost = cap_boost;

  // reserved bits show fixed hardware levels
  wire [31:0] stat_word = {sdlsr_pkg::STAT_TOP_RSV, f_los, 4'h0, f_eq, 1'b0, f_align, 2'h0, f_half,
                           sdlsr_pkg::STAT_MID_RSV, f_boost, 6'h00};
  // Live output status: los pin folded into the hardware-owned bit
  wire [31:0] out_word = {out_reg[31:3], los_sync, 2'h0};

  wire [31:0] next_rdata = hit_stat ? stat_word :
                           hit_out ? out_word :
                           hit_rxo ? rxo_reg :
                           hit_dbg ? dbg_reg :
                           hit_pm ? pm_reg :
                           hit_ec ? ec_reg :
                           hit_fi ? fi_reg :
                           hit_cks ? clk_lvl_sync :
                           hit_cko ? cko_reg : 32'h0000_0000;

  // effective settings follow the override when enabled
  wire [3:0] next_boost = tx_ovrd ? out_reg[sdlsr_pkg::OUT_BOOST_LSB +: 4] : f_boost;
  wire [1:0] next_los = rx_ovrd ? rxo_reg[sdlsr_pkg::RXO_LOS_LSB +: 2] : f_los;
  wire [2:0] next_eq = rx_ovrd ? rxo_reg[sdlsr_pkg::RXO_EQ_LSB +: 3] : f_eq;
  wire next_align = rx_ovrd ? rxo_reg[sdlsr_pkg::RXO_ALIGN_BIT] : f_align;
  wire next_half = rx_ovrd ? rxo_reg[sdlsr_pkg::RXO_HALF_BIT] : f_half;
  // status no longer trusted once any override is on
  wire next_valid = cap_done && !tx_ovrd && !rx_ovrd;
  // unmapped accesses flagged, reads return zero
  wire next_err = (rd || wr) && !hit_any;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
      access_error <= 1'b0;
    end else begin
      rdata <= rd ? next_rdata : 32'h0000_0000;
      access_error <= next_err;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_boost_out <= sdlsr_pkg::BOOST_RST;
      filter_mode_out <= 2'h0;
      rx_eq_out <= sdlsr_pkg::EQ_RST;
      align_en_out <= 1'b0;
      half_rate_out <= 1'b0;
      status_valid <= 1'b0;
    end else begin
      tx_boost_out <= next_boost;
      filter_mode_out <= next_los;
      rx_eq_out <= next_eq;
      align_en_out <= next_align;
      half_rate_out <= next_half;
      status_valid <= next_valid;
    end
  end

  stat_ro_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr && hit_stat) |=> $stable(stat_word))
    else $error("lane status changed by a write");

  boost_field_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && hit_stat) |=> rdata[9:6] == $past(cap_boost))
    else $error("boost field misplaced");

  eq_field_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && hit_stat) |=> rdata[23:21] == $past(cap_eq) && rdata[19] == $past(cap_align))
    else $error("equaliser or align field misplaced");

  half_field_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && hit_stat) |=> rdata[16] == $past(cap_half) && rdata[29:28] == $past(cap_los))
    else $error("half-rate or loss filter field misplaced");

  rsv_fixed_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && hit_stat) |=> rdata[31:30] == 2'h1 && rdata[15:10] == 6'h20 && rdata[5:0] == 6'h00)
    else $error("reserved bits not fixed");

  base_decode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && addr == 12'h800) |=> !access_error && rdata[31:30] == 2'h1)
    else $error("base address not decoded");

  clk_offs_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && (addr == 12'hc20 || addr == 12'hc28 || addr == 12'h82c)) |=> !access_error)
    else $error("mapped offset flagged");

  ovrd_invalid_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tx_ovrd || rx_ovrd) |=> !status_valid)
    else $error("status valid under override");

  ovrd_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tx_ovrd |=> tx_boost_out == $past(out_reg[25:22]))
    else $error("boost override not applied");

  capture_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cap_done |=> $stable(cap_boost) && $stable(cap_eq) && cap_done)
    else $error("power-up levels recaptured");

  capture_time_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!cap_done && cap_cnt == 2'h3) |=> cap_done && {cap_los, cap_eq, cap_align, cap_half, cap_boost} == $past(pin_sync))
    else $error("power-up levels not captured");

  boost_default_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !tx_ovrd |=> tx_boost_out == $past(cap_boost))
    else $error("boost output not the captured level");

  rx_default_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !rx_ovrd |=> filter_mode_out == $past(cap_los) && rx_eq_out == $past(cap_eq))
    else $error("receive outputs not the captured levels");

  rx_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_ovrd |=> filter_mode_out == $past(rxo_reg[13:12]) && rx_eq_out == $past(rxo_reg[7:5]))
    else $error("receive override not applied");

  rx_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_ovrd |=> align_en_out == $past(rxo_reg[3]) && half_rate_out == $past(rxo_reg[0]))
    else $error("align or half-rate override not applied");

  valid_rise_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cap_done && !tx_ovrd && !rx_ovrd) |=> status_valid)
    else $error("status not valid without override");

  below_base_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && !addr[11]) |=> access_error && rdata == 32'h0000_0000)
    else $error("address below base decoded");

  unmapped_err_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && !hit_any) |=> access_error && rdata == 32'h0000_0000)
    else $error("unmapped read not flagged");

  err_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !(rd || wr) |=> !access_error)
    else $error("error flag without access");

  unmapped_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr && !hit_any) |=> $stable(dbg_reg) && $stable(pm_reg) && $stable(cko_reg) && $stable(out_reg))
    else $error("unmapped write changed a register");

  lane_offs_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && (hit_dbg || hit_pm || hit_ec || hit_fi)) |=> !access_error)
    else $error("lane register offset flagged");

  cks_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && hit_cks) |=> rdata == $past(clk_lvl_sync))
    else $error("clock status read wrong");

  cko_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && hit_cko) |=> rdata == $past(cko_reg))
    else $error("clock override read wrong");

  out_los_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && hit_out) |=> rdata[2] == $past(los_sync) && rdata[1:0] == 2'h0)
    else $error("output status hardware bits wrong");

  rdata_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !rd |=> rdata == 32'h0000_0000)
    else $error("read data not zero when idle");

  write_lands_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr && hit_dbg) |=> dbg_reg == $past(wdata))
    else $error("plain register write lost");

  rxo_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr && hit_rxo) |=> rxo_reg[14:0] == $past(wdata[14:0]) && rxo_reg[31:15] == $past(rxo_reg[31:15]))
    else $error("rx override write mask wrong");
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the SerDes lane register bank
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin fail_count++; $display("CHECK FAILED %0t %s", $time, msg); end end
module testbench;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [1:0] signal_loss_filter_mode = 2'h0;
  logic [2:0] receive_equaliser_setting = 3'h0;
  logic align_enable = 1'b0;
  logic half_rate = 1'b0;
  logic [3:0] tx_boost = 4'h0;
  logic serdes_los = 1'b0;
  logic [31:0] clk_level_status = 32'h0000_0000;
  logic [1:0] filter_mode_out;
  logic [2:0] rx_eq_out;
  logic align_en_out;
  logic half_rate_out;
  logic [3:0] tx_boost_out;
  logic status_valid;
  logic access_error;
  int fail_count = 0;
  int tests_run = 0;
  int seed;
  logic [31:0] model[int];
  logic [31:0] wmask[int];
  logic [31:0] w;

  always #5 mclk = ~mclk;

  sdlsr_top uut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .signal_loss_filter_mode(signal_loss_filter_mode), .receive_equaliser_setting(receive_equaliser_setting),
    .align_enable(align_enable), .half_rate(half_rate), .tx_boost(tx_boost), .serdes_los(serdes_los),
    .clk_level_status(clk_level_status), .filter_mode_out(filter_mode_out), .rx_eq_out(rx_eq_out),
    .align_en_out(align_en_out), .half_rate_out(half_rate_out), .tx_boost_out(tx_boost_out),
    .status_valid(status_valid), .access_error(access_error));

  function automatic logic [31:0] lane_stat();
    return {2'b01, signal_loss_filter_mode, 4'h0, receive_equaliser_setting, 1'b0, align_enable, 2'b00,
      half_rate, 6'h20, tx_boost, 6'h00};
  endfunction

  function automatic logic [31:0] exp_read(input logic [11:0] a);
    if (a == 12'h800) return lane_stat();
    if (a == 12'hc20) return clk_level_status;
    if (a == 12'h804) return model[a] | {29'h0, serdes_los, 2'b00};
    if (model.exists(a)) return model[a];
    return 32'h0000_0000;
  endfunction

  task automatic complete_run();
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    if (wmask.exists(a)) model[a] = (model[a] & ~wmask[a]) | (d & wmask[a]);
    #1;
    `CHK(access_error, !wmask.exists(a), "write error flag")
    `CHK(rdata, 32'h0000_0000, "read data idle during write")
  endtask

  task automatic bus_read(input logic [11:0] a, input string msg);
    logic [31:0] e;
    e = exp_read(a);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e, msg)
    `CHK(access_error, !wmask.exists(a), "read error flag")
  endtask

  task automatic reset_model();
    foreach (wmask[k]) model[k] = 32'h0000_0000;
    model[12'h808] = 32'h0000_101e;
  endtask

  task automatic check_effective(input logic ovt, input logic ovr, input logic [31:0] tw, input logic [31:0] rw);
    @(posedge mclk);
    #1;
    `CHK(tx_boost_out, ovt ? tw[25:22] : tx_boost, "boost output")
    `CHK(filter_mode_out, ovr ? rw[13:12] : signal_loss_filter_mode, "filter mode output")
    `CHK(rx_eq_out, ovr ? rw[7:5] : receive_equaliser_setting, "equaliser output")
    `CHK({align_en_out, half_rate_out}, ovr ? {rw[3], rw[0]} : {align_enable, half_rate}, "align half")
    `CHK(status_valid, !(ovt || ovr), "status valid")
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    complete_run();
  end

  initial begin
    seed = 32'h5fbe;
    wmask[12'h800] = 32'h0000_0000;
    wmask[12'hc20] = 32'h0000_0000;
    wmask[12'h804] = 32'hffff_fff8;
    wmask[12'h808] = 32'h0000_7fff;
    wmask[12'h80c] = 32'hffff_ffff;
    wmask[12'h82c] = 32'hffff_ffff;
    wmask[12'h830] = 32'hffff_ffff;
    wmask[12'h834] = 32'hffff_ffff;
    wmask[12'hc28] = 32'hffff_ffff;
    for (int pass = 0; pass < 2; pass++) begin
      w = $random(seed);
      {signal_loss_filter_mode, receive_equaliser_setting, align_enable, half_rate, tx_boost, serdes_los} <= w[11:0];
      clk_level_status <= $random(seed);
      rstn <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      `CHK({tx_boost_out, rx_eq_out, status_valid, access_error}, {4'hb, 3'h2, 2'b00}, "reset outputs")
      reset_model();
      rstn <= 1'b1;
      // no access until the SerDes is out of reset
      repeat (10) @(posedge mclk);
      check_effective(1'b0, 1'b0, 32'h0, 32'h0);
      foreach (wmask[k]) bus_read(12'(k), "reset value");
      bus_write(12'h800, $random(seed));
      bus_read(12'h800, "lane status read only");
      foreach (wmask[k]) begin
        bus_write(12'(k), $random(seed));
        bus_read(12'(k), "write readback");
      end
      bus_write(12'h804, 32'h0000_0000);
      bus_write(12'h808, 32'h0000_101e);
      check_effective(1'b0, 1'b0, 32'h0, 32'h0);
      w = {1'b1, 6'h0, 4'(pass * 5 + 3), 21'h0};
      bus_write(12'h804, w);
      check_effective(1'b1, 1'b0, w, 32'h0);
      bus_read(12'h800, "status ignores tx override");
      bus_write(12'h804, 32'h0000_0000);
      w = {17'h0, 1'b1, 14'($random(seed))};
      bus_write(12'h808, w);
      check_effective(1'b0, 1'b1, 32'h0, w);
      bus_read(12'h800, "status ignores rx override");
      // unassigned offsets and addresses below the base
      bus_read(12'h000, "offset without base");
      bus_read(12'h7fc, "below base");
      bus_read(12'h810, "reserved lane offset");
      bus_read(12'hc24, "reserved clock offset");
      bus_write(12'h838, $random(seed));
      bus_read(12'hffc, "top of space");
    end
    complete_run();
  end
endmodule
